/* File: hw/afs_regs.vh */
`ifndef AFS_REGS_VH
`define AFS_REGS_VH
// Functional notes
// RULE_01 - the set-carry word forces carry to one in one cycle and changes nothing else.
// RULE_02 - the set-zero word forces zero to one in one cycle and changes nothing else.
// RULE_03 - subtract-working-from-register stores register minus working back into the register in one cycle and updates carry, digit carry and zero.
// RULE_04 - after a subtraction carry is cleared on underflow and set when there was none.
// RULE_05 - after a subtraction digit carry is cleared on a low-nibble borrow and set otherwise.
// RULE_06 - after a subtraction zero is set for a zero eight-bit result and cleared otherwise.
// RULE_07 - with the carry-extend option on, the current carry is added into the subtraction result as an inverted borrow.
// RULE_08 - bit-conditional subtract is a bit-test skip then a decrement, and zero changes only when the decrement runs.
// RULE_09 - the nibble-swap word exchanges the two nibbles of the addressed register in one cycle with no flag change.
// RULE_10 - skip-on-zero skips the next word when zero is one, taking two cycles when skipping and one otherwise.
// RULE_11 - a skip discards exactly one following word even inside a multi-word sequence.
// RULE_12 - test on a register or on working sets zero for a zero operand and clears it otherwise, leaving the operand.
// RULE_13 - exclusive OR runs in one cycle as register^working into register, into working, and working^literal into working.
// RULE_14 - after exclusive OR zero follows the result and carry and digit carry stay.
// RULE_15 - f bits form the five-bit register address, k bits the eight-bit literal and b bits the bit index.

// full instruction words
`define AFS_W_SET_CARRY 12'h503
`define AFS_W_SET_ZERO 12'h543
`define AFS_W_SKIP_ZERO 12'h743
`define AFS_W_TEST_W 12'hD00
// seven-bit opcode prefixes of register forms (bits 11..5)
`define AFS_P_SUB 7'h05
`define AFS_P_DEC 7'h07
`define AFS_P_SWAP 7'h1D
`define AFS_P_TEST 7'h11
`define AFS_P_XOR_F 7'h0D
`define AFS_P_XOR_W 7'h0C
// four-bit prefixes of bit and literal forms (bits 11..8)
`define AFS_P_SKIP_CLR 4'h6
`define AFS_P_SKIP_SET 4'h7
`define AFS_P_XOR_LIT 4'hF
// field positions
`define AFS_F_ADDR_HI 4
`define AFS_F_BIT_LO 5
`define AFS_F_LIT_HI 7
// reset values
`define AFS_RST_W 8'h00
`define AFS_RST_FLAGS 1'b0
`endif

/* File: hw/afs_regfile.v */
`timescale 1ns/1ps
// file register array with one combinational read and one write port
module afs_regfile #(
    parameter AW = 5,
    parameter DEPTH = 32
) (
    // clock
    input wire clk,
    // read port
    input wire [AW-1:0] rd_addr,
    output wire [7:0] rd_data,
    // write port
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [7:0] wr_data
);
    reg [7:0] mem [0:DEPTH-1];

    // contents are undefined until written; software owns initialisation
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];
endmodule

/* File: hw/afs_core.v */
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "afs_regs.vh"
// executes one instruction word per cycle from program memory
module afs_core #(
    parameter AW = 5
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // instruction stream
    input wire instr_valid,
    input wire [11:0] instr_word,
    // configuration
    input wire carry_extend_option,
    // register debug port
    input wire [AW-1:0] dbg_addr,
    input wire [7:0] dbg_wdata,
    input wire dbg_wr,
    input wire dbg_rd,
    output reg [7:0] dbg_rdata,
    // state
    output reg carry_flag,
    output reg digit_carry_flag,
    output reg zero_flag,
    output reg [7:0] w_out,
    output reg skip_pending,
    output reg instr_done
);
    reg rst_s1_reg;
    reg rst_s2_reg;
    reg [7:0] w_reg;
    reg skip_reg;
    reg [7:0] w_next;
    reg carry_next;
    reg digit_carry_next;
    reg zero_next;
    reg skip_next;
    reg rf_we;
    reg [7:0] rf_wd;
    reg [AW-1:0] rf_wa;
    reg exec_en;
    wire [AW-1:0] file_addr;
    wire [2:0] bit_idx;
    wire [7:0] lit;
    wire [7:0] file_register_operand;
    wire [6:0] op7;
    wire [3:0] op4;
    wire rst_n;
    reg [8:0] diff;
    reg [4:0] ndiff;
    reg [7:0] res;

    // zero test used by many forms
    function is_zero;
        input [7:0] v;
        begin
            is_zero = (v == 8'h00);
        end
    endfunction

    // two-stage reset release so deassertion is clean
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_n = rst_s2_reg;

    // field extraction
    assign file_addr = instr_word[`AFS_F_ADDR_HI:0]; // RULE_15
    assign bit_idx = instr_word[`AFS_F_BIT_LO+2:`AFS_F_BIT_LO]; // RULE_15
    assign lit = instr_word[`AFS_F_LIT_HI:0]; // RULE_15
    assign op7 = instr_word[11:5];
    assign op4 = instr_word[11:8];

    // debug writes share the port when no instruction writes
    wire [AW-1:0] rd_sel = file_addr;
    wire rfile_we = rf_we | (dbg_wr & ~rf_we);
    wire [AW-1:0] rfile_wa = rf_we ? rf_wa : dbg_addr;
    wire [7:0] rfile_wd = rf_we ? rf_wd : dbg_wdata;
    wire [7:0] dbg_view;

    afs_regfile #(.AW(AW), .DEPTH(1 << AW)) u_rf (
        .clk(clk),
        .rd_addr(rd_sel),
        .rd_data(file_register_operand),
        .wr_en(rfile_we),
        .wr_addr(rfile_wa),
        .wr_data(rfile_wd)
    );

    // second read view for the debug port, from a mirror array given the same writes
    afs_regfile #(.AW(AW), .DEPTH(1 << AW)) u_rf_shadow (
        .clk(clk),
        .rd_addr(dbg_addr),
        .rd_data(dbg_view),
        .wr_en(rfile_we),
        .wr_addr(rfile_wa),
        .wr_data(rfile_wd)
    );

    // decode and execute; a skipped word is consumed with no effect
    always @* begin
        w_next = w_reg;
        carry_next = carry_flag;
        digit_carry_next = digit_carry_flag;
        zero_next = zero_flag;
        skip_next = skip_reg;
        rf_we = 1'b0;
        rf_wa = file_addr;
        rf_wd = file_register_operand;
        exec_en = instr_valid & ~skip_reg;
        diff = 9'h000;
        ndiff = 5'h00;
        res = 8'h00;
        if (instr_valid && skip_reg) begin
            skip_next = 1'b0; // RULE_11
        end
        // full-word forms first: skip-on-zero shares the bit-set-skip prefix
        if (exec_en) begin
            if (instr_word == `AFS_W_SET_CARRY) begin
                carry_next = 1'b1; // RULE_01
            end else if (instr_word == `AFS_W_SET_ZERO) begin
                zero_next = 1'b1; // RULE_02
            end else if (instr_word == `AFS_W_SKIP_ZERO) begin
                skip_next = zero_flag; // RULE_10
            end else if (instr_word == `AFS_W_TEST_W) begin
                zero_next = is_zero(w_reg); // RULE_12
            end else if (op7 == `AFS_P_SUB) begin
                // carry-extend turns carry into an inverted borrow in
                diff = {1'b0, file_register_operand} - {1'b0, w_reg}
                    - {8'h00, (carry_extend_option & ~carry_flag)}; // RULE_07
                ndiff = {1'b0, file_register_operand[3:0]} - {1'b0, w_reg[3:0]}
                    - {4'h0, (carry_extend_option & ~carry_flag)};
                res = diff[7:0];
                rf_we = 1'b1; // RULE_03
                rf_wd = res;
                carry_next = ~diff[8]; // RULE_04
                digit_carry_next = ~ndiff[4]; // RULE_05
                zero_next = is_zero(res); // RULE_06
            end else if (op7 == `AFS_P_DEC) begin
                res = file_register_operand - 8'h01;
                rf_we = 1'b1;
                rf_wd = res;
                zero_next = is_zero(res); // RULE_08
            end else if (op4 == `AFS_P_SKIP_CLR) begin
                skip_next = ~file_register_operand[bit_idx]; // RULE_08
            end else if (op4 == `AFS_P_SKIP_SET) begin
                skip_next = file_register_operand[bit_idx]; // RULE_08
            end else if (op7 == `AFS_P_SWAP) begin
                rf_we = 1'b1;
                rf_wd = {file_register_operand[3:0], file_register_operand[7:4]}; // RULE_09
            end else if (op7 == `AFS_P_TEST) begin
                zero_next = is_zero(file_register_operand); // RULE_12
            end else if (op7 == `AFS_P_XOR_F) begin
                res = file_register_operand ^ w_reg;
                rf_we = 1'b1; // RULE_13
                rf_wd = res;
                zero_next = is_zero(res); // RULE_14
            end else if (op7 == `AFS_P_XOR_W) begin
                res = file_register_operand ^ w_reg;
                w_next = res; // RULE_13
                zero_next = is_zero(res); // RULE_14
            end else if (op4 == `AFS_P_XOR_LIT) begin
                res = lit ^ w_reg;
                w_next = res; // RULE_13
                zero_next = is_zero(res); // RULE_14
            end
        end
    end

    // architectural state; unknown words retire as no-ops
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_reg <= `AFS_RST_W;
            carry_flag <= `AFS_RST_FLAGS;
            digit_carry_flag <= `AFS_RST_FLAGS;
            zero_flag <= `AFS_RST_FLAGS;
            skip_reg <= 1'b0;
            w_out <= `AFS_RST_W;
            skip_pending <= 1'b0;
            instr_done <= 1'b0;
            dbg_rdata <= 8'h00;
        end else begin
            w_reg <= w_next;
            carry_flag <= carry_next;
            digit_carry_flag <= digit_carry_next;
            zero_flag <= zero_next;
            skip_reg <= skip_next;
            w_out <= w_next;
            skip_pending <= skip_next;
            instr_done <= instr_valid;
            if (dbg_rd) begin
                dbg_rdata <= dbg_view;
            end
        end
    end
endmodule

/* File: verif/afs_core_asserts.sv */
`timescale 1ns/1ps
// watches the core ports; words taken while a skip is pending are not executed
module afs_core_asserts #(
    parameter AW = 5
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // instruction stream and configuration
    input wire instr_valid,
    input wire [11:0] instr_word,
    input wire carry_extend_option,
    // register debug port
    input wire [AW-1:0] dbg_addr,
    input wire [7:0] dbg_wdata,
    input wire dbg_wr,
    input wire dbg_rd,
    input wire [7:0] dbg_rdata,
    // state
    input wire carry_flag,
    input wire digit_carry_flag,
    input wire zero_flag,
    input wire [7:0] w_out,
    input wire skip_pending,
    input wire instr_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // a word that really executes
    wire take = instr_valid && !skip_pending;
    AST_SET_CARRY: assert property (take && instr_word == 12'h503
        |=> carry_flag && $stable(zero_flag) && $stable(w_out)) else $error("set carry wrong");
    AST_SET_ZERO: assert property (take && instr_word == 12'h543
        |=> zero_flag && $stable(carry_flag) && $stable(digit_carry_flag))
        else $error("set zero wrong");
    AST_SKIP_ZERO: assert property (take && instr_word == 12'h743
        |=> skip_pending == $past(zero_flag)) else $error("skip decision wrong");
    AST_SKIP_ONE: assert property (instr_valid && skip_pending
        |=> !skip_pending && $stable(w_out) && $stable(zero_flag) && $stable(carry_flag))
        else $error("skipped word acted");
    AST_TEST_W: assert property (take && instr_word == 12'hD00
        |=> zero_flag == ($past(w_out) == 8'h00) && $stable(w_out)) else $error("test w wrong");
    AST_XOR_LIT: assert property (take && instr_word[11:8] == 4'hF
        |=> w_out == ($past(w_out) ^ $past(instr_word[7:0])) && zero_flag == (w_out == 8'h00)
        && $stable(carry_flag) && $stable(digit_carry_flag)) else $error("xor literal wrong");
    AST_SWAP_FLAGS: assert property (take && instr_word[11:5] == 7'h1D
        |=> $stable(carry_flag) && $stable(digit_carry_flag) && $stable(zero_flag))
        else $error("swap touched flags");
    AST_DEC_FLAGS: assert property (take && instr_word[11:5] == 7'h07
        |=> $stable(carry_flag) && $stable(digit_carry_flag)) else $error("decrement flags");
    // every word offered, skipped or not, retires in exactly one cycle
    AST_DONE: assert property (instr_valid |=> instr_done)
        else $error("taken word not retired");
    AST_DONE_IDLE: assert property (!instr_valid |=> !instr_done)
        else $error("retire without a word");
    COV_SKIP: cover property (take && instr_word == 12'h743 && zero_flag);
    COV_SUB: cover property (take && instr_word[11:5] == 7'h05 && carry_extend_option);
    COV_XOR: cover property (take && instr_word[11:8] == 4'hF);
endmodule

bind afs_core afs_core_asserts #(.AW(AW)) u_chk (.clk(clk), .nrst(nrst),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .carry_extend_option(carry_extend_option), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata),
    .dbg_wr(dbg_wr), .dbg_rd(dbg_rd), .dbg_rdata(dbg_rdata), .carry_flag(carry_flag),
    .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag), .w_out(w_out),
    .skip_pending(skip_pending), .instr_done(instr_done));

/* File: verif/afs_pmem.sv */
`timescale 1ns/1ps
// program memory model: hands out queued words one per cycle
module afs_pmem (
    // clock
    input wire clk,
    // instruction stream
    output logic instr_valid,
    output logic [11:0] instr_word
);
    logic [11:0] q[$];
    initial begin
        instr_valid = 1'b0;
        instr_word = 12'h000;
    end
    task automatic push(input logic [11:0] w);
        q.push_back(w);
    endtask
    // idle bus toggles so a stale word is never mistaken for a fresh one
    always @(posedge clk) begin
        if (q.size() > 0) begin
            instr_valid <= 1'b1;
            instr_word <= q.pop_front();
        end else begin
            instr_valid <= 1'b0;
            instr_word <= ~instr_word;
        end
    end
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cx = 1'b0;
    logic [4:0] dbg_addr = 5'h00;
    logic [7:0] dbg_wdata = 8'h00;
    logic dbg_wr = 1'b0;
    logic dbg_rd = 1'b0;
    wire instr_valid, carry_flag, digit_carry_flag, zero_flag, skip_pending, instr_done;
    wire [11:0] instr_word;
    wire [7:0] dbg_rdata, w_out;
    int bad_count = 0;
    int compares = 0;
    logic [8:0] d;
    logic [4:0] lo;
    logic c;
    logic [7:0] fv [5] = '{8'h10, 8'h03, 8'h02, 8'h10, 8'h21};
    always #5 clk = ~clk;
    afs_pmem PM (.clk(clk), .instr_valid(instr_valid), .instr_word(instr_word));
    afs_core DUT (.clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr_word(instr_word),
        .carry_extend_option(cx), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata), .dbg_wr(dbg_wr),
        .dbg_rd(dbg_rd), .dbg_rdata(dbg_rdata), .carry_flag(carry_flag),
        .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag), .w_out(w_out),
        .skip_pending(skip_pending), .instr_done(instr_done));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic fl(input logic [2:0] e);
        chk("flags", {5'h00, e}, {5'h00, carry_flag, digit_carry_flag, zero_flag});
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        @(posedge clk);
        dbg_addr <= a;
        dbg_wdata <= v;
        dbg_wr <= 1'b1;
        @(posedge clk);
        dbg_wr <= 1'b0;
    endtask
    // read data appear in the cycle after the strobe and hold until the next strobe
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk);
        dbg_addr <= a;
        dbg_rd <= 1'b1;
        @(posedge clk);
        dbg_rd <= 1'b0;
        #1 chk("file reg", e, dbg_rdata);
    endtask
    // words go back to back, one taken per cycle
    task automatic run(input logic [11:0] ws[$]);
        @(negedge clk);
        foreach (ws[i]) PM.push(ws[i]);
        repeat (ws.size() + 2) @(posedge clk);
        #1;
    endtask
    task automatic results;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #20000;
        bad_count++;
        results();
    end
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        fl(3'b000);
        chk("w", 8'h00, w_out);
        run('{12'h503, 12'hF03});
        fl(3'b100);
        c = 1'b1;
        // subtract table with w = 03; the last two rows run with carry-extend on,
        // first with carry clear, then with carry set
        for (int i = 0; i < 5; i++) begin
            wr(5'(i + 5), fv[i]);
            cx <= (i >= 3);
            d = {1'b0, fv[i]} - 9'h003 - {8'h00, (i >= 3) & ~c};
            lo = {1'b0, fv[i][3:0]} - 5'h03 - {4'h0, (i >= 3) & ~c};
            run('{12'h0A5 + 12'(i)});
            c = ~d[8];
            rd(5'(i + 5), d[7:0]);
            fl({~d[8], ~lo[4], d[7:0] == 8'h00});
        end
        cx <= 1'b0;
        wr(5'h09, 8'hA5);
        run('{12'h3A9});
        rd(5'h09, 8'h5A);
        fl(3'b100);
        run('{12'h543});
        fl(3'b101);
        run('{12'h743, 12'hF55, 12'hF0F});
        chk("w", 8'h0C, w_out);
        run('{12'h743, 12'hF0C});
        chk("w", 8'h00, w_out);
        wr(5'h0A, 8'h00);
        run('{12'hF03, 12'h22A});
        fl(3'b101);
        rd(5'h0A, 8'h00);
        run('{12'hD00});
        fl(3'b100);
        wr(5'h0B, 8'h03);
        run('{12'h1AB});
        rd(5'h0B, 8'h00);
        fl(3'b101);
        run('{12'h18B});
        chk("w", 8'h03, w_out);
        fl(3'b100);
        wr(5'h0C, 8'h01);
        run('{12'h70C, 12'h0EC});
        rd(5'h0C, 8'h01);
        fl(3'b100);
        run('{12'h60C, 12'h0EC});
        rd(5'h0C, 8'h00);
        fl(3'b101);
        results();
    end
endmodule
